//--- design/rcs_pkg.sv
package rcs_pkg;

  // ---------------------------------------------------------------
  // Register map (index, byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_IDX = 8'h04;
  localparam logic [7:0] XCTL_IDX = 8'h05;
  localparam logic [7:0] HOLD_IDX = 8'h08;
  localparam logic [7:0] CTRL_ADR = 8'h10;
  localparam logic [7:0] XCTL_ADR = 8'h14;
  localparam logic [7:0] HOLD_ADR = 8'h20;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int LOAD_BIT = 1;
  localparam int SNAP_BIT = 0;
  localparam int FAIL_BIT = 5;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  XCTL_RST = 8'h00;
  localparam logic [31:0] HOLD_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MISS_TIME_NS  = 100000;
  localparam int MISS_CYC_INT  = MISS_TIME_NS / CLK_PERIOD_NS;
  localparam logic [12:0] MISS_CYCLES = 13'(MISS_CYC_INT);
  localparam logic [1:0]  SLOW_EDGES  = 2'h2;

  typedef struct packed {
    logic osc_en;
    logic mcd_en;
    logic fail;
    logic run;
    logic rsv;
    logic fast;
    logic load;
    logic snap;
  } rcs_ctrl_t;

  typedef struct packed {
    logic       gain_en;
    logic       xtal_mode;
    logic       bias_dbl;
    logic       valid;
    logic       lf_sel;
    logic [2:0] unused;
  } rcs_xctl_t;

endpackage : rcs_pkg

//--- design/rcs_regs.sv
// Notes on behaviour
// [RULE1] Control bit 7 switches oscillator on/off
// [RULE2] Control bit 6 enables missing-clock detector
// [RULE3] Fail flag set by timeout, software clears
// [RULE4] Software ignores fail flag while oscillator off
// [RULE5] Bit 4 runs timer; cleared holds value
// [RULE6] Bit 3 reserved, reads zero, write zero
// [RULE7] Software sets fast mode when sysclk fast
// [RULE8] Bit 1 loads timer, clears when done
// [RULE9] Bit 0 snapshots timer, clears when done
// [RULE10] Oscillator-control bit 7 enables gain control
// [RULE11] Bit 6 picks crystal or self-oscillate
// [RULE12] Bit 5 enables bias doubling
// [RULE13] Read-only bit 4 reports sufficient amplitude
// [RULE14] Crystal valid reads zero without bias doubling
// [RULE15] Bit 3 selects internal LF source, overriding
// [RULE16] Bits 2:0 read zero, writes ignored
// [RULE17] Detector fires after 100 us stuck clock
// [RULE18] Slow-mode transfers need running timer, two cycles
// [RULE19] Running timer increments each oscillator cycle
// [RULE20] Writing zero never cancels pending transfer
`timescale 1ns/100ps
`default_nettype none
module rcs_regs
  import rcs_pkg::*;
(
  // System
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // Wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output var  logic [31:0] DAT_O,
  output var  logic        ACK_O,
  // Oscillator pins
  input  wire logic        RTC_OSC_IN,
  input  wire logic        AMP_OK_IN,
  // Oscillator controls
  output var  logic        OSC_ENABLE,
  output var  logic        MCD_ENABLE,
  output var  logic        GAIN_CTRL_EN,
  output var  logic        CRYSTAL_MODE,
  output var  logic        BIAS_DOUBLE_EN,
  output var  logic        LF_SOURCE_EN,
  // Timer
  output var  logic        TIMER_RUN,
  output var  logic [31:0] TIMER_VALUE
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  rcs_ctrl_t   ctrl_q,   ctrl_d;
  rcs_xctl_t   xctl_q,   xctl_d;
  logic [31:0] hold_q,   hold_d;
  logic [31:0] timer_q,  timer_d;
  logic [31:0] dat_q,    dat_d;
  logic        ack_q;
  logic [12:0] miss_q,   miss_d;
  logic [1:0]  edges_q,  edges_d;
  logic        osc_r1_q, osc_r2_q, osc_r3_q;
  logic        amp_r1_q, amp_r2_q;
  logic        valid_q;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire         req       = CYC_I & STB_I;
  wire         wr_lane   = req & ack_q & WE_I & SEL_I[0];
  wire         hit_ctrl  = ADR_I == CTRL_ADR;
  wire         hit_xctl  = ADR_I == XCTL_ADR;
  wire         hit_hold  = ADR_I == HOLD_ADR;
  wire         wr_ctrl   = wr_lane & hit_ctrl;
  wire         wr_xctl   = wr_lane & hit_xctl;
  wire         wr_hold   = req & ack_q & WE_I & hit_hold;
  wire         osc_rise  = osc_r2_q & ~osc_r3_q;
  wire         osc_chg   = osc_r2_q ^ osc_r3_q;
  wire         pending   = ctrl_q.load | ctrl_q.snap;
  wire         det_on    = ctrl_q.osc_en & ctrl_q.mcd_en;                        // RULE2
  wire         miss_hit  = det_on & ~osc_chg & (miss_q == MISS_CYCLES - 13'h1); // RULE17
  wire         slow_step = pending & ~ctrl_q.fast & ctrl_q.run & osc_rise;       // RULE18
  wire         xfer_done = pending &                                             // RULE18
                           (ctrl_q.fast | (slow_step & (edges_q == SLOW_EDGES - 2'h1)));
  wire         do_load   = xfer_done & ctrl_q.load;
  wire         do_snap   = xfer_done & ctrl_q.snap;
  wire [7:0]   ctrl_rd   = {ctrl_q[7:4], 1'b0, ctrl_q[2:0]};                     // RULE6
  // Gated again here so a read never lags a bias-double clear
  wire [7:0]   xctl_rd   = {xctl_q.gain_en, xctl_q.xtal_mode, xctl_q.bias_dbl,
                            valid_q & xctl_q.bias_dbl, xctl_q.lf_sel, 3'h0};     // RULE14 RULE16

  assign dat_d = ~hit_ctrl & ~hit_xctl & ~hit_hold ? 32'h0000_0000 :
                 hit_hold ? hold_q :
                 hit_ctrl ? {24'h00_0000, ctrl_rd} : {24'h00_0000, xctl_rd};

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.osc_en = DAT_I[7]; // RULE1
      ctrl_d.mcd_en = DAT_I[6]; // RULE2
      ctrl_d.run    = DAT_I[4]; // RULE5
      ctrl_d.fast   = DAT_I[2];
    end
    ctrl_d.rsv  = 1'b0; // RULE6
    // Set wins over a clear in the same cycle
    ctrl_d.fail = miss_hit | (ctrl_q.fail & ~(wr_ctrl & ~DAT_I[FAIL_BIT])); // RULE3
    // A zero write leaves a pending transfer alone
    ctrl_d.load = (ctrl_q.load & ~xfer_done) | (wr_ctrl & DAT_I[LOAD_BIT]); // RULE8 RULE20
    ctrl_d.snap = (ctrl_q.snap & ~xfer_done) | (wr_ctrl & DAT_I[SNAP_BIT]); // RULE9 RULE20
  end

  always_comb begin
    xctl_d = xctl_q;
    if (wr_xctl) begin
      xctl_d.gain_en   = DAT_I[7]; // RULE10
      xctl_d.xtal_mode = DAT_I[6]; // RULE11
      xctl_d.bias_dbl  = DAT_I[5]; // RULE12
      xctl_d.lf_sel    = DAT_I[3]; // RULE15
    end
    xctl_d.valid  = 1'b0;
    xctl_d.unused = 3'h0; // RULE16
  end

  // ---------------------------------------------------------------
  // Timer, holding register, detector counters
  // ---------------------------------------------------------------
  assign timer_d = do_load ? hold_q :                                   // RULE8
                   (ctrl_q.run & osc_rise) ? timer_q + 32'h0000_0001 :  // RULE19
                   timer_q;                                             // RULE5
  // Software writes cannot race a snapshot: the copy wins
  assign hold_d  = do_snap ? timer_q :                                  // RULE9
                   wr_hold ? {SEL_I[3] ? DAT_I[31:24] : hold_q[31:24],
                              SEL_I[2] ? DAT_I[23:16] : hold_q[23:16],
                              SEL_I[1] ? DAT_I[15:8]  : hold_q[15:8],
                              SEL_I[0] ? DAT_I[7:0]   : hold_q[7:0]} : hold_q;
  // One-shot: counter saturates so the flag fires once per stall
  assign miss_d  = (~det_on | osc_chg) ? 13'h0000 :
                   (miss_q == MISS_CYCLES) ? miss_q : miss_q + 13'h0001; // RULE17
  assign edges_d = (~pending | xfer_done) ? 2'h0 :
                   slow_step ? edges_q + 2'h1 : edges_q;                  // RULE18

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_q  <= CTRL_RST;
      xctl_q  <= XCTL_RST;
      hold_q  <= HOLD_RST;
      timer_q <= 32'h0000_0000;
      miss_q  <= 13'h0000;
      edges_q <= 2'h0;
    end else begin
      ctrl_q  <= ctrl_d;
      xctl_q  <= xctl_d;
      hold_q  <= hold_d;
      timer_q <= timer_d;
      miss_q  <= miss_d;
      edges_q <= edges_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      osc_r1_q <= 1'b0;
      osc_r2_q <= 1'b0;
      osc_r3_q <= 1'b0;
      amp_r1_q <= 1'b0;
      amp_r2_q <= 1'b0;
      valid_q  <= 1'b0;
    end else begin
      osc_r1_q <= RTC_OSC_IN;
      osc_r2_q <= osc_r1_q;
      osc_r3_q <= osc_r2_q;
      amp_r1_q <= AMP_OK_IN;
      amp_r2_q <= amp_r1_q;
      valid_q  <= amp_r2_q & xctl_q.bias_dbl; // RULE13 RULE14
    end
  end

  // ---------------------------------------------------------------
  // Bus answer and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      dat_q <= (req & ~ack_q) ? dat_d : dat_q;
    end
  end

  assign DAT_O          = dat_q;
  assign ACK_O          = ack_q;
  assign OSC_ENABLE     = ctrl_q.osc_en;
  assign MCD_ENABLE     = ctrl_q.mcd_en;
  assign TIMER_RUN      = ctrl_q.run;
  assign TIMER_VALUE    = timer_q;
  assign GAIN_CTRL_EN   = xctl_q.gain_en;
  assign CRYSTAL_MODE   = xctl_q.xtal_mode;
  assign BIAS_DOUBLE_EN = xctl_q.bias_dbl;
  // Internal LF source overrides the crystal choice
  assign LF_SOURCE_EN   = xctl_q.lf_sel; // RULE15

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence slow_last_s;
    pending & ~ctrl_q.fast & ctrl_q.run & osc_rise & (edges_q == 2'h1) & ~wr_ctrl;
  endsequence

  sequence stall_s;
    det_on & ~osc_chg & (miss_q == MISS_CYCLES - 13'h1);
  endsequence

  sequence fast_snap_s;
    ctrl_q.snap & ctrl_q.fast & ~wr_ctrl;
  endsequence

  sequence parked_s;
    pending & ~ctrl_q.fast & ~ctrl_q.run;
  endsequence

  // ---------------------------------------------------------------
  // Bus handshake and read path
  // ---------------------------------------------------------------
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack held two cycles");
  ack_answer_a: assert property (req & ~ACK_O |=> ACK_O)
    else $error("request not answered next cycle");
  rd_rsv_a: assert property (ACK_O & hit_ctrl |-> DAT_O[3] == 1'b0) // RULE6
    else $error("reserved control bit read nonzero");
  rd_unused_a: assert property (ACK_O & hit_xctl |-> // RULE14 RULE16
      DAT_O[2:0] == 3'h0 && (BIAS_DOUBLE_EN || !DAT_O[4]))
    else $error("unused or gated oscillator-control bits read nonzero");
  unmapped_zero_a: assert property (ACK_O & ~hit_ctrl & ~hit_xctl & ~hit_hold |-> DAT_O == 32'h0)
    else $error("unmapped read nonzero");

  // ---------------------------------------------------------------
  // Control bits and detector
  // ---------------------------------------------------------------
  enable_bits_a: assert property (wr_ctrl |=> OSC_ENABLE == $past(DAT_I[7])) // RULE1
    else $error("oscillator enable not written");
  ctrl_pins_a: assert property (wr_ctrl |=> // RULE2 RULE5
      MCD_ENABLE == $past(DAT_I[6]) && TIMER_RUN == $past(DAT_I[4]))
    else $error("control pins not written");
  fail_sticky_a: assert property (ctrl_q.fail & ~wr_ctrl |=> ctrl_q.fail) // RULE3
    else $error("fail flag lost");
  fail_set_a: assert property (stall_s |=> ctrl_q.fail) // RULE17
    else $error("fail flag not set on timeout");
  set_wins_a: assert property (miss_hit & wr_ctrl |=> ctrl_q.fail) // RULE3
    else $error("clear beat a timeout in the same cycle");
  detector_off_a: assert property (!det_on & ~ctrl_q.fail |=> !ctrl_q.fail) // RULE2
    else $error("fail flag set with detector off");
  miss_bound_a: assert property (miss_q <= MISS_CYCLES) // RULE17
    else $error("stall counter past its ceiling");
  rsv_zero_a: assert property (ctrl_q.rsv == 1'b0 && xctl_q.unused == 3'h0) // RULE6
    else $error("reserved bit nonzero");

  // ---------------------------------------------------------------
  // Oscillator control
  // ---------------------------------------------------------------
  xctl_pins_a: assert property (wr_xctl |=> // RULE10 RULE11 RULE12 RULE15
      GAIN_CTRL_EN == $past(DAT_I[7]) && CRYSTAL_MODE == $past(DAT_I[6]) &&
      BIAS_DOUBLE_EN == $past(DAT_I[5]) && LF_SOURCE_EN == $past(DAT_I[3]))
    else $error("oscillator control pins not written");
  valid_gate_a: assert property (!xctl_q.bias_dbl ##1 !xctl_q.bias_dbl |-> !valid_q) // RULE14
    else $error("crystal valid without bias doubling");
  valid_follow_a: assert property (xctl_q.bias_dbl & amp_r2_q |=> valid_q) // RULE13
    else $error("crystal valid missed sufficient amplitude");

  // ---------------------------------------------------------------
  // Transfers and timer
  // ---------------------------------------------------------------
  fast_done_a: assert property (ctrl_q.load & ctrl_q.fast & ~wr_ctrl |=> !ctrl_q.load) // RULE8
    else $error("fast load not done");
  slow_done_a: assert property (slow_last_s |=> !ctrl_q.load && !ctrl_q.snap) // RULE18
    else $error("slow transfer not done");
  parked_a: assert property (parked_s |=> // RULE18
      (ctrl_q.load | ~$past(ctrl_q.load)) && (ctrl_q.snap | ~$past(ctrl_q.snap)))
    else $error("slow transfer finished with timer stopped");
  snap_copy_a: assert property (fast_snap_s |=> !ctrl_q.snap && hold_q == $past(timer_q)) // RULE9
    else $error("snapshot not copied");
  load_copy_a: assert property (do_load |=> TIMER_VALUE == $past(hold_q)) // RULE8
    else $error("timer not loaded from holding register");
  hold_write_a: assert property (wr_hold & ~do_snap & SEL_I[0] |=> // RULE8
      hold_q[7:0] == $past(DAT_I[7:0]))
    else $error("holding register lane not written");
  zero_keep_a: assert property (ctrl_q.snap & ~xfer_done |=> ctrl_q.snap) // RULE20
    else $error("pending snapshot cancelled");
  timer_hold_a: assert property (!TIMER_RUN & ~do_load |=> $stable(TIMER_VALUE)) // RULE5
    else $error("stopped timer moved");
  timer_inc_a: assert property (TIMER_RUN & osc_rise & ~do_load |=> // RULE19
      TIMER_VALUE == $past(TIMER_VALUE) + 32'h0000_0001)
    else $error("timer did not increment");

endmodule : rcs_regs
`default_nettype wire

//--- test/test_rcs_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_rcs_regs
  import rcs_pkg::*;
;
  // ---------------------------------------------------------------
  // Bench signals
  // ---------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic        osc     = 1'b0;
  logic        amp     = 1'b0;
  logic        osc_go  = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [3:0]  sel     = 4'h0;
  logic [3:0]  sel_w   = 4'hF;
  logic [31:0] dat     = 32'h0;
  logic [31:0] rd, hv, v, dat_o, tval;
  logic        ack, osc_en, mcd_en, gain, crystal_mode_select, bias, lf, run;
  integer      seed = 32'hDD39;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          rises = 0;
  int          ph = 0;
  int          i;

  rcs_regs dut (
    .SYS_CLK(sys_clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .RTC_OSC_IN(osc),
    .AMP_OK_IN(amp), .OSC_ENABLE(osc_en), .MCD_ENABLE(mcd_en), .GAIN_CTRL_EN(gain),
    .CRYSTAL_MODE(crystal_mode_select), .BIAS_DOUBLE_EN(bias), .LF_SOURCE_EN(lf), .TIMER_RUN(run),
    .TIMER_VALUE(tval)
  );

  always #12.5 sys_clk = ~sys_clk;

  // Slow oscillator, stands still when not wanted
  always @(posedge sys_clk) begin
    if (osc_go) begin
      ph <= (ph == 5) ? 0 : ph + 1;
      if (ph == 5) begin
        osc <= ~osc;
        if (!osc) rises <= rises + 1;
      end
    end
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Classic cycle; ack sampled before the edge updates land
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= sel_w;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) chk("ack", 32'h0, 32'h1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdc

  // Poll bounded; a stuck request bit shows as a mismatch
  task wait_clear(input int b);
    int k;
    for (k = 0; k < 30 && (k == 0 || rd[b] !== 1'b0); k++) wb(1'b0, CTRL_ADR, 32'h0);
    chk("request_done", 32'(rd[b]), 32'h0);
  endtask : wait_clear

  function automatic logic [31:0] exp_ctrl(input logic [7:0] w);
    return {24'h0, w & 8'hD4};
  endfunction : exp_ctrl

  function automatic logic [31:0] exp_xctl(input logic [7:0] w, input logic a);
    return {24'h0, (w & 8'hE8) | {3'h0, a & w[5], 4'h0}};
  endfunction : exp_xctl

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rdc("ctrl_reset", CTRL_ADR, 32'h0);
    rdc("xctl_reset", XCTL_ADR, 32'h0);
    chk("pins_reset", 32'({osc_en, mcd_en, gain, crystal_mode_select, bias, lf, run}), 32'h0);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      amp <= v[16];
      wb(1'b1, CTRL_ADR, {24'h0, v[7:0] & 8'hF4});
      wb(1'b1, XCTL_ADR, {24'h0, v[15:8]});
      rdc("ctrl", CTRL_ADR, exp_ctrl(v[7:0]));
      rdc("xctl", XCTL_ADR, exp_xctl(v[15:8], v[16]));
      chk("ctrl_pins", 32'({osc_en, mcd_en, run}), 32'({v[7], v[6], v[4]}));
      chk("xctl_pins", 32'({gain, crystal_mode_select, bias, lf}), 32'({v[15:13], v[11]}));
    end
    wb(1'b1, 8'h30, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h30, 32'h0);
    sel_w = 4'h2;
    wb(1'b1, CTRL_ADR, 32'hFF);
    wb(1'b1, HOLD_ADR, 32'hA5A5_A5A5);
    sel_w = 4'hF;
    rdc("lane_ignored", CTRL_ADR, exp_ctrl(v[7:0]));
    rdc("hold_lanes", HOLD_ADR, 32'h0000_A500);
    $display("test fields done");
    hv = $random(seed);
    wb(1'b1, HOLD_ADR, hv);
    wb(1'b1, CTRL_ADR, 32'h86);
    wait_clear(LOAD_BIT);
    repeat (20) @(posedge sys_clk);
    chk("timer_load", tval, hv);
    wb(1'b1, CTRL_ADR, 32'h94);
    rises <= 0;
    osc_go <= 1'b1;
    repeat (120) @(posedge sys_clk);
    osc_go <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("timer_count", tval, hv + 32'(rises));
    wb(1'b1, CTRL_ADR, 32'h95);
    wait_clear(SNAP_BIT);
    rdc("snapshot", HOLD_ADR, hv + 32'(rises));
    wb(1'b1, CTRL_ADR, 32'h81);
    rdc("slow_pending", CTRL_ADR, 32'h81);
    wb(1'b1, CTRL_ADR, 32'h90);
    rdc("zero_no_cancel", CTRL_ADR, 32'h91);
    osc_go <= 1'b1;
    wait_clear(SNAP_BIT);
    osc_go <= 1'b0;
    $display("test transfers done");
    wb(1'b1, CTRL_ADR, 32'h84);
    repeat (4100) @(posedge sys_clk);
    rdc("detector_off", CTRL_ADR, 32'h84);
    wb(1'b1, CTRL_ADR, 32'hC4);
    repeat (4100) @(posedge sys_clk);
    rdc("fail_set", CTRL_ADR, 32'hE4);
    wb(1'b1, CTRL_ADR, 32'h84);
    rdc("fail_clear", CTRL_ADR, 32'h84);
    $display("test detector done");
    close_out();
  end
endmodule : test_rcs_regs
`default_nettype wire
